/* verilog/sdd_pkg.sv */
// Function
// - three-bit code picks one of eight trip levels
// - status high while supply below trip level
// - enable bit powers detector on or off
// - sleep forces detector off despite enable
// - request flag set after fixed delay from status
// - request set in sleep or idle wakes core; here only a detector set of a clear flag in idle wakes
// - reference enabled automatically while detector used
// - status follows comparator unfiltered, may toggle
// - per-source enable and flag, plus global enable
package sdd_pkg;

	localparam int unsigned CLK_PERIOD_PS         = 25000;
	localparam int unsigned IRQ_ASSERT_DELAY_NS   = 1000;
	localparam int unsigned IRQ_ASSERT_DELAY_CYC  =
		(IRQ_ASSERT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DETECTOR_SETTLE_NS    = 2000;
	localparam int unsigned DETECTOR_SETTLE_CYC   =
		(DETECTOR_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam logic [7:0]  ADDR_CONTROL          = 8'h00;
	localparam logic [7:0]  ADDR_IRQ_CTRL         = 8'h04;
	localparam logic [7:0]  ADDR_EVENT_STATUS     = 8'h08;
	localparam logic [7:0]  ADDR_EVENT_MASK       = 8'h0C;

	localparam int unsigned CTRL_LEVEL_LSB        = 0;
	localparam int unsigned CTRL_LEVEL_W          = 3;
	localparam int unsigned CTRL_REF_BIT          = 3;
	localparam int unsigned CTRL_EN_BIT           = 4;
	localparam int unsigned CTRL_STATUS_BIT       = 5;
	localparam logic [7:0]  CTRL_RESET            = 8'h00;

	localparam int unsigned IRQ_GIE_BIT           = 0;
	localparam int unsigned IRQ_EN_BIT            = 1;
	localparam int unsigned IRQ_FLAG_BIT          = 2;
	localparam int unsigned IRQ_SETTLED_BIT       = 3;

	localparam int unsigned EV_W                  = 4;
	localparam int unsigned EV_FLAG_SET           = 0;
	localparam int unsigned EV_LOW_RISE           = 1;
	localparam int unsigned EV_LOW_FALL           = 2;
	localparam int unsigned EV_WAKE               = 3;
	localparam logic [3:0]  EV_RESET              = 4'h0;

	typedef logic [CTRL_LEVEL_W-1:0] sdd_level_t;

	typedef enum logic [1:0] {
		SDD_OFF,
		SDD_SETTLING,
		SDD_READY
	} sdd_det_state_t;

endpackage : sdd_pkg

/* verilog/sdd_if.sv */
`timescale 1ns/1ps
interface sdd_if;
	logic cmp_sync;
	logic arm;
	logic fire;

	modport sync_mp  (output cmp_sync);
	modport delay_mp (input arm, output fire);
	modport top_mp   (input cmp_sync, output arm, input fire);
endinterface : sdd_if

/* verilog/sdd_sync.sv */
`timescale 1ns/1ps
module sdd_sync
	import sdd_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic cmp_low_async,
	sdd_if.sync_mp    ifc
);
	typedef struct packed {
		logic meta;
		logic stable;
	} sdd_sync_state_t;

	sdd_sync_state_t st_q;
	sdd_sync_state_t st_d;

	always_comb begin
		st_d        = st_q;
		st_d.meta   = cmp_low_async;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ifc.cmp_sync = st_q.stable;
endmodule : sdd_sync

/* verilog/sdd_delay.sv */
`timescale 1ns/1ps
module sdd_delay
	import sdd_pkg::*;
#(
	parameter int unsigned DELAY_CYC = IRQ_ASSERT_DELAY_CYC
)(
	input  wire logic pclk,
	input  wire logic presetn,
	sdd_if.delay_mp   ifc
);
	localparam int unsigned CW = (DELAY_CYC < 2) ? 1 : $clog2(DELAY_CYC + 1);

	if (DELAY_CYC < 1 || DELAY_CYC > 4096) begin : g_bad_delay
		$error("sdd_delay: DELAY_CYC out of range");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          done;
		logic          fire;
	} sdd_delay_state_t;

	sdd_delay_state_t st_q;
	sdd_delay_state_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.fire = 1'b0;
		if (!ifc.arm) begin
			st_d.cnt  = '0;
			st_d.done = 1'b0;
		end else if (!st_q.done) begin
			if (st_q.cnt == CW'(DELAY_CYC - 1)) begin
				st_d.done = 1'b1;
				st_d.fire = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ifc.fire = st_q.fire;
endmodule : sdd_delay

/* verilog/sdd_top.sv */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module sdd_top
	import sdd_pkg::*;
#(
	parameter int unsigned IRQ_DELAY_CYC = IRQ_ASSERT_DELAY_CYC,
	parameter int unsigned SETTLE_CYC    = DETECTOR_SETTLE_CYC
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_low_async,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	output logic [2:0]       trip_level_select,
	output logic             detector_power_on,
	output logic             reference_on,
	output logic             irq_req,
	output logic             wake_req,
	output logic             irq
);
	localparam int unsigned SW = (SETTLE_CYC < 2) ? 1 : $clog2(SETTLE_CYC + 1);

	if (SETTLE_CYC < 1 || SETTLE_CYC > 4096) begin : g_bad_settle
		$error("sdd_top: SETTLE_CYC out of range");
	end

	typedef struct packed {
		sdd_level_t      level;
		logic            ref_bit;
		logic            det_en;
		logic            low_status;
		logic            glob_en;
		logic            droop_en;
		logic            droop_flag;
		sdd_det_state_t  det_state;
		logic [SW-1:0]   settle_cnt;
		logic [EV_W-1:0] ev_status;
		logic [EV_W-1:0] ev_mask;
		logic            wake;
		logic [31:0]     rdata;
	} sdd_top_state_t;

	sdd_top_state_t st_q;
	sdd_top_state_t st_d;

	sdd_if ifc ();

	sdd_sync u_sync (
		.pclk          (pclk),
		.presetn       (presetn),
		.cmp_low_async (cmp_low_async),
		.ifc           (ifc.sync_mp)
	);

	sdd_delay #(
		.DELAY_CYC (IRQ_DELAY_CYC)
	) u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.ifc     (ifc.delay_mp)
	);

	assign ifc.arm = st_q.low_status;

	// decoded bus phases
	logic        setup_ph;
	logic        access_ph;
	logic        addr_hit;
	logic        wr_ctrl;
	logic        wr_irq;
	logic        wr_stat;
	logic        wr_mask;
	logic        det_on;
	logic        low_now;
	logic        low_rise;
	logic        low_fall;
	logic        flag_set;
	logic        wake_set;
	logic        settled;
	logic [EV_W-1:0] ev_set;
	logic [31:0] rd_mux;

	always_comb begin
		setup_ph  = psel & ~penable;
		access_ph = psel & penable;
		addr_hit  = (paddr == ADDR_CONTROL) | (paddr == ADDR_IRQ_CTRL) |
			(paddr == ADDR_EVENT_STATUS) | (paddr == ADDR_EVENT_MASK);
		wr_ctrl   = access_ph & pwrite & (paddr == ADDR_CONTROL);
		wr_irq    = access_ph & pwrite & (paddr == ADDR_IRQ_CTRL);
		wr_stat   = access_ph & pwrite & (paddr == ADDR_EVENT_STATUS);
		wr_mask   = access_ph & pwrite & (paddr == ADDR_EVENT_MASK);
	end

	// detector power and reference
	always_comb begin
		det_on  = st_q.det_en & ~sleep_mode;
		low_now = det_on & ifc.cmp_sync;
		settled = (st_q.det_state == SDD_READY);
	end

	// edge and event detection
	always_comb begin
		low_rise = low_now & ~st_q.low_status;
		low_fall = ~low_now & st_q.low_status;
		flag_set = ifc.fire & det_on;
		wake_set = flag_set & ~st_q.droop_flag & (sleep_mode | idle_mode);
		ev_set   = '0;
		ev_set[EV_FLAG_SET] = flag_set;
		ev_set[EV_LOW_RISE] = low_rise;
		ev_set[EV_LOW_FALL] = low_fall;
		ev_set[EV_WAKE]     = wake_set;
	end

	// read data selection
	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			ADDR_CONTROL: begin
				rd_mux[CTRL_LEVEL_LSB +: CTRL_LEVEL_W] = st_q.level;
				rd_mux[CTRL_REF_BIT]                   = st_q.ref_bit;
				rd_mux[CTRL_EN_BIT]                    = st_q.det_en;
				rd_mux[CTRL_STATUS_BIT]                = st_q.low_status;
			end
			ADDR_IRQ_CTRL: begin
				rd_mux[IRQ_GIE_BIT]     = st_q.glob_en;
				rd_mux[IRQ_EN_BIT]      = st_q.droop_en;
				rd_mux[IRQ_FLAG_BIT]    = st_q.droop_flag;
				rd_mux[IRQ_SETTLED_BIT] = settled;
			end
			ADDR_EVENT_STATUS: begin
				rd_mux[EV_W-1:0] = st_q.ev_status;
			end
			ADDR_EVENT_MASK: begin
				rd_mux[EV_W-1:0] = st_q.ev_mask;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// next state
	always_comb begin
		st_d = st_q;

		// status mirrors the comparator with no filter
		st_d.low_status = low_now;

		// settle tracking after enable
		unique case (st_q.det_state)
			SDD_OFF: begin
				st_d.settle_cnt = '0;
				if (det_on) begin
					st_d.det_state = SDD_SETTLING;
				end
			end
			SDD_SETTLING: begin
				if (!det_on) begin
					st_d.det_state = SDD_OFF;
				end else if (st_q.settle_cnt == SW'(SETTLE_CYC - 1)) begin
					st_d.det_state = SDD_READY;
				end else begin
					st_d.settle_cnt = st_q.settle_cnt + 1'b1;
				end
			end
			SDD_READY: begin
				if (!det_on) begin
					st_d.det_state = SDD_OFF;
				end
			end
			default: begin
				st_d.det_state = SDD_OFF;
			end
		endcase

		// control register
		if (wr_ctrl) begin
			st_d.level   = pwdata[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
			st_d.ref_bit = pwdata[CTRL_REF_BIT];
			st_d.det_en  = pwdata[CTRL_EN_BIT];
		end

		// enable and flag pair, plus global enable
		if (wr_irq) begin
			st_d.glob_en    = pwdata[IRQ_GIE_BIT];
			st_d.droop_en   = pwdata[IRQ_EN_BIT];
			st_d.droop_flag = pwdata[IRQ_FLAG_BIT];
		end
		if (flag_set) begin
			st_d.droop_flag = 1'b1;
		end

		// sticky events, write one to clear, set wins
		st_d.ev_status = st_q.ev_status;
		if (wr_stat) begin
			st_d.ev_status = st_q.ev_status & ~pwdata[EV_W-1:0];
		end
		st_d.ev_status = st_d.ev_status | ev_set;

		if (wr_mask) begin
			st_d.ev_mask = pwdata[EV_W-1:0];
		end

		// wake request held until the core leaves low power
		if (wake_set) begin
			st_d.wake = 1'b1;
		end else if (!sleep_mode && !idle_mode) begin
			st_d.wake = 1'b0;
		end

		// read data captured in setup phase
		if (setup_ph && !pwrite) begin
			st_d.rdata = rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q            <= '0;
			st_q.level      <= CTRL_RESET[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
			st_q.ref_bit    <= CTRL_RESET[CTRL_REF_BIT];
			st_q.det_en     <= CTRL_RESET[CTRL_EN_BIT];
			st_q.det_state  <= SDD_OFF;
			st_q.ev_status  <= EV_RESET;
			st_q.ev_mask    <= EV_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// bus answer: zero wait states, error on unmapped address
	assign pready  = access_ph;
	assign pslverr = access_ph & ~addr_hit;
	assign prdata  = st_q.rdata;

	assign trip_level_select = st_q.level;
	assign detector_power_on = det_on;
	assign reference_on      = det_on | st_q.ref_bit;
	assign irq_req  = st_q.droop_flag & st_q.droop_en & st_q.glob_en;
	assign wake_req = st_q.wake;
	assign irq      = |(st_q.ev_status & st_q.ev_mask);
endmodule : sdd_top

/* verif/sdd_chk.sv */
`timescale 1ns/1ps
module sdd_chk
	import sdd_pkg::*;
#(
	parameter int unsigned IRQ_DELAY_CYC = 40
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cmp_low_async,
	input wire logic        sleep_mode,
	input wire logic        idle_mode,
	input wire logic [2:0]  trip_level_select,
	input wire logic        detector_power_on,
	input wire logic        reference_on,
	input wire logic        wake_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] run_q;
	wire         mapped = paddr inside {ADDR_CONTROL, ADDR_IRQ_CTRL, ADDR_EVENT_STATUS,
		ADDR_EVENT_MASK};
	// cycles of powered low comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_q <= 16'h0000;
		else
			run_q <= (cmp_low_async && detector_power_on) ? run_q + 16'h0001 : 16'h0000;
	end
	sequence s_acc; psel && penable; endsequence
	sequence s_wr; s_acc ##0 (pwrite && paddr == ADDR_CONTROL); endsequence
	property p_lvl; s_wr |=> trip_level_select == $past(pwdata[2:0]); endproperty
	a_lvl: assert property (p_lvl) else $error("level not taken");
	property p_keep; !(psel && penable && pwrite && paddr == ADDR_CONTROL)
		|=> $stable(trip_level_select); endproperty
	a_keep: assert property (p_keep) else $error("level changed");
	property p_pwr; s_wr |=> detector_power_on == ($past(pwdata[4]) && !sleep_mode); endproperty
	a_pwr: assert property (p_pwr) else $error("power wrong");
	property p_sleep; sleep_mode |-> !detector_power_on; endproperty
	a_sleep: assert property (p_sleep) else $error("on in sleep");
	property p_ref; detector_power_on |-> reference_on; endproperty
	a_ref: assert property (p_ref) else $error("reference off");
	property p_dly; $rose(wake_req) |-> run_q >= IRQ_DELAY_CYC + 3; endproperty
	a_dly: assert property (p_dly) else $error("flag too early");
	property p_wake; wake_req && !sleep_mode && !idle_mode |-> ##[1:2] !wake_req; endproperty
	a_wake: assert property (p_wake) else $error("wake stuck");
	property p_apb; s_acc |-> pready && pslverr == !mapped; endproperty
	a_apb: assert property (p_apb) else $error("bad answer");
endmodule : sdd_chk

/* verif/sdd_cmp_model.sv */
`timescale 1ns/1ps
module sdd_cmp_model (
	input  wire logic [2:0] trip_level_select,
	input  wire logic       detector_power_on,
	input  wire logic       reference_on,
	input  wire logic [3:0] supply_step,
	output logic            cmp_low_async
);
	// unfiltered, silent when unpowered
	assign cmp_low_async = detector_power_on && reference_on
		&& (supply_step <= {1'b0, trip_level_select});
endmodule : sdd_cmp_model

/* verif/sdd_tb_top.sv */
`timescale 1ns/1ps
module sdd_tb_top
	import sdd_pkg::*;
;
	localparam int unsigned DLY = 6;
	localparam int unsigned STL = 5;
	logic        pclk, presetn, psel, penable, pwrite, sleep_mode, idle_mode, er;
	logic        pready, pslverr, cmp_low_async, detector_power_on, reference_on;
	logic        irq_req, wake_req, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  trip_level_select;
	logic [3:0]  supply_step;
	int          err_count = 0;
	int          checks_done = 0;
	sdd_top #(
		.IRQ_DELAY_CYC (DLY),
		.SETTLE_CYC    (STL)
	) u_dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.cmp_low_async     (cmp_low_async),
		.sleep_mode        (sleep_mode),
		.idle_mode         (idle_mode),
		.trip_level_select (trip_level_select),
		.detector_power_on (detector_power_on),
		.reference_on      (reference_on),
		.irq_req           (irq_req),
		.wake_req          (wake_req),
		.irq               (irq)
	);
	sdd_cmp_model u_cmp (
		.trip_level_select (trip_level_select),
		.detector_power_on (detector_power_on),
		.reference_on      (reference_on),
		.supply_step       (supply_step),
		.cmp_low_async     (cmp_low_async)
	);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0);
			chk(32'(er), 32'(i == 4));
		end
		$display("reset test done");
	endtask : t_reset
	task automatic t_levels();
		@(posedge pclk);
		supply_step <= 4'h3;
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, ADDR_CONTROL, 32'h10 | k);
			tick(5);
			chk(32'(trip_level_select), 32'(k));
			apb(1'b0, ADDR_CONTROL, 32'h0);
			chk(rd, 32'h10 | k | (k >= 3 ? 32'h20 : 32'h0));
		end
		$display("level test done");
	endtask : t_levels
	task automatic t_power();
		apb(1'b1, ADDR_CONTROL, 32'h0);
		tick(1);
		chk(32'({detector_power_on, reference_on}), 32'h0);
		apb(1'b1, ADDR_CONTROL, 32'h8);
		tick(1);
		chk(32'({detector_power_on, reference_on}), 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h17);
		apb(1'b0, ADDR_IRQ_CTRL, 32'h0);
		chk(32'(rd[3]), 32'h0);
		tick(STL + 2);
		apb(1'b0, ADDR_IRQ_CTRL, 32'h0);
		chk(32'(rd[3]), 32'h1);
		chk(32'({detector_power_on, reference_on}), 32'h3);
		@(posedge pclk);
		sleep_mode <= 1'b1;
		tick(4);
		chk(32'(detector_power_on), 32'h0);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk(rd, 32'h17);
		@(posedge pclk);
		sleep_mode <= 1'b0;
		$display("power test done");
	endtask : t_power
	task automatic t_irq();
		@(posedge pclk);
		supply_step <= 4'h8;
		idle_mode <= 1'b1;
		apb(1'b1, ADDR_IRQ_CTRL, 32'h3);
		apb(1'b1, ADDR_EVENT_STATUS, 32'hF);
		apb(1'b1, ADDR_EVENT_MASK, 32'hF);
		@(posedge pclk);
		supply_step <= 4'h2;
		tick(DLY + 3);
		chk(32'(irq_req), 32'h0);
		tick(1);
		chk(32'({irq_req, wake_req, irq}), 32'h7);
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0);
		chk(rd, 32'hB);
		apb(1'b1, ADDR_EVENT_STATUS, 32'hF);
		@(posedge pclk);
		supply_step <= 4'h8;
		tick(4);
		@(posedge pclk);
		supply_step <= 4'h2;
		tick(4);
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0);
		chk(rd, 32'h6);
		tick(10);
		@(posedge pclk);
		idle_mode <= 1'b0;
		tick(3);
		chk(32'(wake_req), 32'h0);
		apb(1'b1, ADDR_IRQ_CTRL, 32'h6);
		tick(1);
		chk(32'(irq_req), 32'h0);
		apb(1'b1, ADDR_IRQ_CTRL, 32'h3);
		apb(1'b1, ADDR_EVENT_MASK, 32'h0);
		tick(1);
		chk(32'({irq_req, irq}), 32'h0);
		$display("irq test done");
	endtask : t_irq
	task automatic t_preset();
		@(posedge pclk);
		supply_step <= 4'h8;
		idle_mode <= 1'b1;
		apb(1'b1, ADDR_IRQ_CTRL, 32'h7);
		@(posedge pclk);
		supply_step <= 4'h2;
		tick(DLY + 8);
		chk(32'(wake_req), 32'h0);
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0);
		chk(rd, 32'h7);
		$display("preset test done");
	endtask : t_preset
	initial begin
		{presetn, psel, penable, pwrite, sleep_mode, idle_mode} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		supply_step = 4'h8;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_levels();
		t_power();
		t_irq();
		t_preset();
		final_report();
	end
	initial begin
		repeat (3000) @(posedge pclk);
		err_count++;
		final_report();
	end
endmodule : sdd_tb_top
bind sdd_top sdd_chk #(.IRQ_DELAY_CYC(IRQ_DELAY_CYC)) u_chk (
	.pclk              (pclk),
	.presetn           (presetn),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pwdata            (pwdata),
	.pready            (pready),
	.pslverr           (pslverr),
	.cmp_low_async     (cmp_low_async),
	.sleep_mode        (sleep_mode),
	.idle_mode         (idle_mode),
	.trip_level_select (trip_level_select),
	.detector_power_on (detector_power_on),
	.reference_on      (reference_on),
	.wake_req          (wake_req)
);
